//--- logic/brp_pkg.sv
package brp_pkg;
	// Bus geometry and response codes
	localparam int AXI_AW = 8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Register byte offsets
	localparam logic [7:0] OFS_TIMER2_COUNT_CNT = 8'h00;
	localparam logic [7:0] OFS_TIMER2_COUNT_CTL = 8'h04;
	localparam logic [7:0] OFS_TIMER2_COUNT_PER = 8'h08;
	localparam logic [7:0] OFS_TIMER4_COUNT_CNT = 8'h0c;
	localparam logic [7:0] OFS_TIMER4_COUNT_CTL = 8'h10;
	localparam logic [7:0] OFS_TIMER4_COUNT_PER = 8'h14;
	localparam logic [7:0] OFS_DUTY_LO = 8'h18;
	localparam logic [7:0] OFS_DUTY_HI = 8'h1c;
	localparam logic [7:0] OFS_UNIT_CTL = 8'h20;
	localparam logic [7:0] OFS_AS_CTL = 8'h24;
	localparam logic [7:0] OFS_DB_RST = 8'h28;
	localparam logic [7:0] OFS_FLAGS = 8'h2c;
	localparam logic [7:0] OFS_TMR_SEL = 8'h30;
	localparam logic [7:0] OFS_PIN_DIR = 8'h34;
	// Field positions
	localparam int ASE_BIT = 7;
	localparam int RSEN_BIT = 7;
	localparam int TON_BIT = 2;
	localparam int FLAG2_BIT = 1;
	localparam int FLAG4_BIT = 3;
	localparam int DC_LSB = 4;
	localparam int CFG_LSB = 6;
	localparam int SRC_LSB = 4;
	localparam int PSS_AC_LSB = 2;
	localparam int PSS_BD_LSB = 0;
	// Reset values and timer control read mask
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] PER_RST = 8'hff;
	localparam logic [3:0] PIN_DIR_RST = 4'hf;
	localparam logic [7:0] TCTL_MASK = 8'h7f;
	// Prescaler limits for 1, 4 and 16
	localparam logic [3:0] PRE_LIM_1 = 4'h0;
	localparam logic [3:0] PRE_LIM_4 = 4'h3;
	localparam logic [3:0] PRE_LIM_16 = 4'hf;
	// Output configuration modes
	typedef enum logic [1:0] {
		CFG_SINGLE = 2'b00,
		CFG_FWD = 2'b01,
		CFG_HALF = 2'b10,
		CFG_REV = 2'b11
	} brp_cfg_type;
endpackage : brp_pkg

//--- logic/brp_top.sv
// Functional notes
// R01 - Auto restart only when restart bit set
// R02 - Auto restart: status follows cause, self-clears
// R03 - No auto restart: status stays until firmware
// R04 - Resume output only at next period start
// R05 - Status writes ignored while cause active
// R06 - Comparator shutdown is a level, blocks clear
// R07 - Writing one to status forces shutdown
// R08 - Mode bits 1:0 set pair polarities
// R09 - Software picks polarity before enabling pins
// R10 - Timer flag marks second period start
// R11 - Software waits one cycle before enabling pins
// R12 - Period comes from selected timer period
// R13 - Duty is low byte plus control bits 5:4
// R14 - Top control bits pick output configuration
// R15 - Half-bridge applies seven-bit dead band
// R16 - Software programs fields, then sets status
// R17 - Software clears status, configures, waits
// R18 - Timer prescale bits 1:0, run bit 2
// R19 - Software waits flag, enables pins, clears status
// R20 - Reset restores registers, pins become inputs
// R21 - Hardware sets status on selected event
// R22 - Source select codes 000 to 111
// R23 - Pair shutdown state: low, high, tri-state
// R24 - Status set at period start holds period
`timescale 1ns/1ps
module brp_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [brp_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [brp_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Shutdown sources
	input wire logic comp1_out,
	input wire logic comp2_out,
	input wire logic fault_input_n,
	// Bridge pins
	output logic bridge_out_a,
	output logic bridge_out_b,
	output logic bridge_out_c,
	output logic bridge_out_d,
	output logic bridge_oe_a_n,
	output logic bridge_oe_b_n,
	output logic bridge_oe_c_n,
	output logic bridge_oe_d_n
);
	import brp_pkg::*;

	// Bus state
	logic aw_have_r, w_have_r, w_lane0_r, wr_fire, rd_ok;
	logic [7:0] aw_addr_r, w_data_r, wr_addr, rd_val;

	// Registers
	logic [7:0] tcnt_r [2], tctl_r [2], tper_r [2];
	logic [3:0] pre_r [2];
	logic [1:0] flag_r, wrap;
	logic [1:0] frac [2];
	logic [7:0] duty_lo_r;
	logic [9:0] duty_lat_r;
	logic [7:0] unit_ctl_r;
	logic [6:0] as_cfg_r;
	logic ase_r;
	logic sd_hold_r;
	logic [7:0] db_rst_r;
	logic tsel_r;
	logic [3:0] pin_dir_r;

	// Datapath
	logic cause, boundary, pwm_mode, pwm_raw, pwm_prev_r;
	logic [6:0] db_cnt_r;
	logic db_busy, sd_active;
	logic [3:0] lvl, hiz;
	brp_cfg_type cfg;

	assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
	assign wr_addr = {aw_addr_r[7:2], 2'b00};

	// Write channel: address and data taken in either order
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= REG_RST;
			w_data_r <= REG_RST;
			w_lane0_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata[7:0];
				w_lane0_r <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_addr <= OFS_PIN_DIR) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read decode
	always_comb begin
		rd_ok = 1'b1;
		rd_val = REG_RST;
		case ({s_axi_araddr[7:2], 2'b00})
			OFS_TIMER2_COUNT_CNT: rd_val = tcnt_r[0];
			OFS_TIMER2_COUNT_CTL: rd_val = tctl_r[0] & TCTL_MASK;
			OFS_TIMER2_COUNT_PER: rd_val = tper_r[0];
			OFS_TIMER4_COUNT_CNT: rd_val = tcnt_r[1];
			OFS_TIMER4_COUNT_CTL: rd_val = tctl_r[1] & TCTL_MASK;
			OFS_TIMER4_COUNT_PER: rd_val = tper_r[1];
			OFS_DUTY_LO: rd_val = duty_lo_r;
			OFS_DUTY_HI: rd_val = duty_lat_r[9:2];
			OFS_UNIT_CTL: rd_val = unit_ctl_r;
			OFS_AS_CTL: rd_val = {ase_r, as_cfg_r};
			OFS_DB_RST: rd_val = db_rst_r;
			OFS_FLAGS: rd_val = {4'h0, flag_r[1], 1'b0, flag_r[0], 1'b0};
			OFS_TMR_SEL: rd_val = {7'h00, tsel_r};
			OFS_PIN_DIR: rd_val = {4'h0, pin_dir_r};
			default: rd_ok = 1'b0;
		endcase
	end

	// Read channel: data one cycle after the address is taken
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_val};
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Plain configuration registers
	always_ff @(posedge ref_clk) begin
		// R20 reset state
		if (!reset_n) begin
			tctl_r[0] <= REG_RST;
			tctl_r[1] <= REG_RST;
			tper_r[0] <= PER_RST;
			tper_r[1] <= PER_RST;
			duty_lo_r <= REG_RST;
			unit_ctl_r <= REG_RST;
			as_cfg_r <= 7'h00;
			db_rst_r <= REG_RST;
			tsel_r <= 1'b0;
			pin_dir_r <= PIN_DIR_RST;
		end else if (wr_fire & w_lane0_r) begin
			case (wr_addr)
				OFS_TIMER2_COUNT_CTL: tctl_r[0] <= w_data_r;
				OFS_TIMER2_COUNT_PER: tper_r[0] <= w_data_r;
				OFS_TIMER4_COUNT_CTL: tctl_r[1] <= w_data_r;
				OFS_TIMER4_COUNT_PER: tper_r[1] <= w_data_r;
				OFS_DUTY_LO: duty_lo_r <= w_data_r;
				OFS_UNIT_CTL: unit_ctl_r <= w_data_r;
				OFS_AS_CTL: as_cfg_r <= w_data_r[6:0];
				OFS_DB_RST: db_rst_r <= w_data_r;
				OFS_TMR_SEL: tsel_r <= w_data_r[0];
				OFS_PIN_DIR: pin_dir_r <= w_data_r[3:0];
				default: ;
			endcase
		end
	end

	// Two period timers
	for (genvar t = 0; t < 2; t++) begin : g_tmr
		logic [3:0] lim;
		logic cnt_wr;
		logic flag_wr;
		// R18 prescale select
		assign lim = (tctl_r[t][1:0] == 2'b00) ? PRE_LIM_1 :
			(tctl_r[t][1:0] == 2'b01) ? PRE_LIM_4 : PRE_LIM_16;
		assign frac[t] = (lim == PRE_LIM_16) ? pre_r[t][3:2] : pre_r[t][1:0];
		assign cnt_wr = wr_fire & w_lane0_r &
			(wr_addr == ((t == 0) ? OFS_TIMER2_COUNT_CNT : OFS_TIMER4_COUNT_CNT));
		assign flag_wr = wr_fire & w_lane0_r & (wr_addr == OFS_FLAGS);
		// R12 period match from timer period register
		assign wrap[t] = tctl_r[t][TON_BIT] & (pre_r[t] == lim) &
			(tcnt_r[t] == tper_r[t]);

		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				tcnt_r[t] <= REG_RST;
				pre_r[t] <= 4'h0;
			end else if (cnt_wr) begin
				tcnt_r[t] <= w_data_r;
				pre_r[t] <= 4'h0;
			// R18 run bit
			end else if (tctl_r[t][TON_BIT]) begin
				if (pre_r[t] >= lim) begin
					pre_r[t] <= 4'h0;
					tcnt_r[t] <= wrap[t] ? 8'h00 : tcnt_r[t] + 8'h01;
				end else begin
					pre_r[t] <= pre_r[t] + 4'h1;
				end
			end
		end

		// R10 overflow flag, set wins over clear
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				flag_r[t] <= 1'b0;
			end else if (wrap[t]) begin
				flag_r[t] <= 1'b1;
			end else if (flag_wr) begin
				flag_r[t] <= w_data_r[(t == 0) ? FLAG2_BIT : FLAG4_BIT];
			end
		end
	end

	assign boundary = wrap[tsel_r];

	// R13 duty latched at each period start
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			duty_lat_r <= 10'h000;
		end else if (boundary) begin
			duty_lat_r <= {duty_lo_r, unit_ctl_r[DC_LSB+1:DC_LSB]};
		end
	end

	// R22 source select decode
	assign cause = (as_cfg_r[SRC_LSB] & comp1_out) |
		(as_cfg_r[SRC_LSB+1] & comp2_out) |
		(as_cfg_r[SRC_LSB+2] & ~fault_input_n);

	// Shutdown status; a live cause outranks every write
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ase_r <= 1'b0;
		// R21 hardware set
		// R06 level cause keeps it set
		end else if (cause) begin
			ase_r <= 1'b1;
		// R05 write only lands with no cause
		// R07 write one forces shutdown
		// R03 write zero is the firmware clear
		end else if (wr_fire & w_lane0_r & (wr_addr == OFS_AS_CTL)) begin
			ase_r <= w_data_r[ASE_BIT];
		// R01 auto restart gate
		// R02 self-clear once cause is gone
		end else if (db_rst_r[RSEN_BIT]) begin
			ase_r <= 1'b0;
		end
	end

	// R24 hold for the period that began in shutdown
	// R04 release only at a period start
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sd_hold_r <= 1'b0;
		end else if (ase_r) begin
			sd_hold_r <= 1'b1;
		end else if (boundary) begin
			sd_hold_r <= 1'b0;
		end
	end

	assign sd_active = ase_r | sd_hold_r;
	assign pwm_mode = unit_ctl_r[3:2] == 2'b11;
	assign pwm_raw = pwm_mode &
		({tcnt_r[tsel_r], frac[tsel_r]} < duty_lat_r);
	assign cfg = brp_cfg_type'(unit_ctl_r[CFG_LSB+1:CFG_LSB]);

	// R15 dead band restarts on every edge of the modulation
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pwm_prev_r <= 1'b0;
			db_cnt_r <= 7'h00;
		end else begin
			pwm_prev_r <= pwm_raw;
			if (pwm_raw != pwm_prev_r) begin
				db_cnt_r <= db_rst_r[6:0];
			end else if (db_cnt_r != 7'h00) begin
				db_cnt_r <= db_cnt_r - 7'h01;
			end
		end
	end
	// Edge cycle counts as the first dead cycle, so the gap is exact
	assign db_busy = (pwm_raw != pwm_prev_r) ? (db_rst_r[6:0] != 7'h00) :
		(db_cnt_r > 7'h01);

	// Pin levels, active-high before polarity; order is d c b a
	always_comb begin
		lvl = 4'h0;
		hiz = 4'h0;
		// R14 configuration and direction
		case (cfg)
			CFG_SINGLE: lvl = {3'b000, pwm_raw};
			CFG_FWD: lvl = {pwm_raw, 2'b00, pwm_mode};
			// R15 half-bridge dead band
			CFG_HALF: lvl = {2'b00, ~pwm_raw & ~db_busy & pwm_mode,
				pwm_raw & ~db_busy};
			CFG_REV: lvl = {1'b0, pwm_mode, pwm_raw, 1'b0};
			default: lvl = 4'h0;
		endcase
		// R08 pair polarity, bit 1 for A/C, bit 0 for B/D
		if (pwm_mode) begin
			lvl = lvl ^ {unit_ctl_r[0], unit_ctl_r[1],
				unit_ctl_r[0], unit_ctl_r[1]};
		end
		// R23 pair shutdown states
		if (sd_active) begin
			lvl = {as_cfg_r[PSS_BD_LSB], as_cfg_r[PSS_AC_LSB],
				as_cfg_r[PSS_BD_LSB], as_cfg_r[PSS_AC_LSB]};
			hiz = {as_cfg_r[PSS_BD_LSB+1], as_cfg_r[PSS_AC_LSB+1],
				as_cfg_r[PSS_BD_LSB+1], as_cfg_r[PSS_AC_LSB+1]};
		end
	end

	// Pins registered; direction bits high leave a pin undriven
	always_ff @(posedge ref_clk) begin
		// R20 pins start as inputs
		if (!reset_n) begin
			{bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a} <= 4'h0;
			{bridge_oe_d_n, bridge_oe_c_n, bridge_oe_b_n, bridge_oe_a_n}
				<= 4'hf;
		end else begin
			{bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a} <= lvl;
			{bridge_oe_d_n, bridge_oe_c_n, bridge_oe_b_n, bridge_oe_a_n}
				<= pin_dir_r | hiz;
		end
	end

endmodule : brp_top

//--- testbench/brp_bridge.sv
`timescale 1ns/1ps
module brp_bridge (
	// Levels and enables, bits d c b a
	input wire logic [3:0] lvl,
	input wire logic [3:0] oe_n,
	// Gate levels seen by the switches
	output logic [3:0] gate
);
	// Gate pull-downs hold every switch off while its pin floats
	assign gate = lvl & ~oe_n;
endmodule : brp_bridge

//--- testbench/brp_chk.sv
`timescale 1ns/1ps
module brp_chk (
	// Clock, reset and write channel
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [brp_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// Shutdown sources
	input wire logic comp1_out,
	input wire logic comp2_out,
	input wire logic fault_input_n,
	// Bridge pins
	input wire logic bridge_out_a,
	input wire logic bridge_out_b,
	input wire logic bridge_out_c,
	input wire logic bridge_out_d,
	input wire logic bridge_oe_a_n,
	input wire logic bridge_oe_b_n,
	input wire logic bridge_oe_c_n,
	input wire logic bridge_oe_d_n
);
	import brp_pkg::*;
	logic [7:0] rg_r [0:15];
	logic [5:0] quiet_r;
	logic wr_hs, cause, pwm, sd_ok;
	logic [7:0] ctl, asc;
	assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign ctl = rg_r[8];
	assign asc = rg_r[9];
	assign pwm = ctl[3:2] == 2'b11;
	assign cause = |(asc[6:4] & {!fault_input_n, comp2_out, comp1_out});
	// Tri-stated pairs have no defined level, so only driven pairs count
	assign sd_ok = (asc[3] || (bridge_out_a == asc[2] && bridge_out_c == asc[2]))
		&& (asc[1] || (bridge_out_b == asc[0] && bridge_out_d == asc[0]));
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < 16; i++) begin
				rg_r[i] <= REG_RST;
			end
		end else if (wr_hs && s_axi_wstrb[0] && s_axi_awaddr[7:6] == 2'b00) begin
			rg_r[s_axi_awaddr[5:2]] <= s_axi_wdata[7:0];
		end
	end
	// Settling time since the last write, saturating
	always_ff @(posedge ref_clk) begin
		if (!reset_n || wr_hs) begin
			quiet_r <= 6'h00;
		end else if (quiet_r != 6'h3f) begin
			quiet_r <= quiet_r + 6'h01;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	AST_RST_INPUTS: assert property (disable iff (1'b0)
		!reset_n |=> bridge_oe_a_n && bridge_oe_b_n && bridge_oe_c_n && bridge_oe_d_n)
		else $error("pins not released by reset");
	AST_SD_ENTER: assert property (pwm && cause |-> ##2 sd_ok)
		else $error("shutdown levels missing");
	AST_SD_TRI: assert property (pwm && cause && asc[1]
		|-> ##2 bridge_oe_b_n && bridge_oe_d_n) else $error("pair not released");
	AST_NO_RESTART: assert property (pwm && !rg_r[10][7] && cause ##1 !cause
		|-> ##1 sd_ok [*6]) else $error("restart without firmware");
	AST_HOLD_PERIOD: assert property (pwm && rg_r[10][7] && cause ##1 !cause
		|-> ##1 sd_ok) else $error("outputs left shutdown early");
	AST_FORCE: assert property (pwm && wr_hs && s_axi_awaddr == OFS_AS_CTL
		&& s_axi_wdata[ASE_BIT] |-> ##[2:4] sd_ok) else $error("forced shutdown lost");
	AST_DEAD_GAP: assert property (ctl[7:6] == CFG_HALF && ctl[1:0] == 2'b00
		&& !asc[2] && !asc[0] |-> !(bridge_out_a && bridge_out_b
		&& !bridge_oe_a_n && !bridge_oe_b_n)) else $error("both switches on");
	AST_POLARITY: assert property (pwm && ctl[7:6] == CFG_SINGLE
		&& quiet_r == 6'h3f && asc[3:2] == {1'b0, ctl[1]} && asc[1:0] == {1'b0, ctl[0]}
		|-> bridge_out_c == ctl[1] && bridge_out_b == ctl[0] && bridge_out_d == ctl[0])
		else $error("idle level wrong");
endmodule : brp_chk
bind brp_top brp_chk chk_u (.*);

//--- testbench/bridge_pwm_shutdown_restart_test.sv
`timescale 1ns/1ps
module bridge_pwm_shutdown_restart_test;
	import brp_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [AXI_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic comp1_out = 1'b0, comp2_out = 1'b0, fault_input_n = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d;
	logic bridge_oe_a_n, bridge_oe_b_n, bridge_oe_c_n, bridge_oe_d_n;
	logic [3:0] gate;
	logic [7:0] rd_val;
	int err_total = 0, n_compared = 0, cyc = 0, na, nb;
	always #2 ref_clk = ~ref_clk;
	brp_top dut_u (.*);
	brp_bridge bridge_u (
		.lvl({bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a}),
		.oe_n({bridge_oe_d_n, bridge_oe_c_n, bridge_oe_b_n, bridge_oe_a_n}),
		.gate(gate)
	);
	task automatic finish_test;
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] resp = RESP_OKAY);
		logic aw_left, w_left;
		aw_left = 1'b1;
		w_left = 1'b1;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw_left || w_left) begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1) begin
				aw_left = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				w_left = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({6'h00, s_axi_bresp}, {6'h00, resp});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp,
		input logic [1:0] resp = RESP_OKAY, input bit cmp = 1'b1);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd_val = s_axi_rdata[7:0];
		if (cmp) begin
			chk(rd_val, exp);
			chk({6'h00, s_axi_rresp}, {6'h00, resp});
		end
	endtask : rd
	// A hung handshake ends the run here
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			$display("Error at %0t: run timed out", $time);
			finish_test();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		chk({4'h0, bridge_oe_d_n, bridge_oe_c_n, bridge_oe_b_n, bridge_oe_a_n}, 8'h0f);
		rd(OFS_AS_CTL, REG_RST);
		rd(OFS_DB_RST, REG_RST);
		rd(OFS_TIMER2_COUNT_PER, PER_RST);
		rd(OFS_PIN_DIR, {4'h0, PIN_DIR_RST});
		wr(8'h38, 8'h5a, RESP_SLVERR);
		rd(8'h38, 8'h00, RESP_SLVERR);
		// Configure everything while the pins are still inputs
		wr(OFS_TIMER2_COUNT_PER, 8'h0f);
		wr(OFS_UNIT_CTL, 8'h8c);
		wr(OFS_DUTY_LO, 8'h08);
		wr(OFS_DB_RST, 8'h03);
		wr(OFS_AS_CTL, 8'h18);
		wr(OFS_AS_CTL, 8'h98);
		wr(OFS_FLAGS, 8'h00);
		wr(OFS_TIMER2_COUNT_CTL, 8'h04);
		rd(OFS_FLAGS, 8'h00);
		while (rd_val[FLAG2_BIT] !== 1'b1) rd(OFS_FLAGS, 8'h00, RESP_OKAY, 1'b0);
		wr(OFS_PIN_DIR, 8'h00);
		wr(OFS_AS_CTL, 8'h18);
		rd(OFS_DUTY_HI, 8'h08);
		repeat (20) @(posedge ref_clk);
		na = 0;
		nb = 0;
		// Four whole periods, so the count is free of alignment
		repeat (64) begin
			@(posedge ref_clk);
			na += gate[0];
			nb += gate[1];
		end
		chk(na[7:0], 8'h14);
		chk(nb[7:0], 8'h14);
		comp1_out <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk({4'h0, gate}, 8'h00);
		chk({7'h0, bridge_oe_a_n}, 8'h01);
		wr(OFS_AS_CTL, 8'h18);
		rd(OFS_AS_CTL, 8'h98);
		comp1_out <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd(OFS_AS_CTL, 8'h98);
		wr(OFS_AS_CTL, 8'h18);
		repeat (20) @(posedge ref_clk);
		chk({7'h0, bridge_oe_a_n}, 8'h00);
		wr(OFS_DB_RST, 8'h83);
		for (int s = 0; s < 8; s++) begin
			wr(OFS_AS_CTL, {1'b0, s[2:0], 4'ha});
			for (int k = 0; k < 3; k++) begin
				{fault_input_n, comp2_out, comp1_out} <= {k != 2, k == 1, k == 0};
				repeat (3) @(posedge ref_clk);
				chk({7'h0, bridge_oe_b_n}, {7'h0, s[k]});
				rd(OFS_AS_CTL, {s[k], s[2:0], 4'ha});
				{fault_input_n, comp2_out, comp1_out} <= 3'b100;
				repeat (3) @(posedge ref_clk);
				rd(OFS_AS_CTL, {1'b0, s[2:0], 4'ha});
				repeat (20) @(posedge ref_clk);
			end
		end
		wr(OFS_DB_RST, 8'h03);
		wr(OFS_AS_CTL, 8'h8a);
		@(posedge ref_clk);
		chk({6'h0, bridge_oe_b_n, bridge_oe_a_n}, 8'h03);
		// Polarity changes only while the pins are inputs
		wr(OFS_PIN_DIR, 8'h0f);
		wr(OFS_AS_CTL, 8'h05);
		wr(OFS_UNIT_CTL, 8'h0f);
		wr(OFS_PIN_DIR, 8'h00);
		repeat (70) @(posedge ref_clk);
		chk({5'h0, gate[3:1]}, 8'h07);
		finish_test();
	end
endmodule : bridge_pwm_shutdown_restart_test
